// ===== design/vis_pkg.sv
// Purpose: constants and types for the vectored interrupt source block
// Assumes: one 40 MHz system clock, CPU core on the same clock
// Notes: vector addresses and priorities are fixed by the hardware
package vis_pkg;

	// ************************************************************
	// Counts and widths
	// ************************************************************
	localparam int VIS_NUM_MASKABLE = 16;
	localparam int VIS_NUM_EXT = 3;
	localparam int VIS_PRIO_W = 4;
	localparam int VIS_VEC_W = 16;

	// ************************************************************
	// Vector table addresses
	// ************************************************************
	localparam logic [15:0] VIS_VEC_NMI = 16'h0004;
	localparam logic [15:0] VIS_VEC_MASK_BASE = 16'h0004;
	localparam logic [15:0] VIS_VEC_SOFTWARE = 16'h003e;
	localparam logic [15:0] VIS_VEC_NONE = 16'h0000;

	// ************************************************************
	// Maskable source positions, index equals default priority
	// ************************************************************
	localparam int VIS_SRC_WDT_INTERVAL = 0;
	localparam int VIS_SRC_EXT0 = 1;
	localparam int VIS_SRC_WAKEUP = 4;
	localparam int VIS_SRC_T16_CH0 = 5;
	localparam int VIS_SRC_T16_CH1 = 6;
	localparam int VIS_SRC_TIMER_SIX = 7;
	localparam int VIS_SRC_TIMER_EIGHTY = 8;
	localparam int VIS_SRC_TIMER_EIGHTYONE = 9;
	localparam int VIS_SRC_BUS_XFER = 10;
	localparam int VIS_SRC_BUS_RX_ERR = 11;
	localparam int VIS_SRC_CSI_END = 12;
	localparam int VIS_SRC_UART_RX = 13;
	localparam int VIS_SRC_UART_TX = 14;
	localparam int VIS_SRC_ADC_END = 15;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [15:0] VIS_PEND_RST = 16'h0000;
	localparam logic [1:0] VIS_SYNC_RST = 2'h0;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [1:0] {
		VIS_EDGE_RISE = 2'b00,
		VIS_EDGE_FALL = 2'b01,
		VIS_EDGE_BOTH = 2'b10,
		VIS_EDGE_OFF = 2'b11
	} vis_edge_t;

	typedef enum logic [1:0] {
		VIS_KIND_NONE = 2'b00,
		VIS_KIND_NMI = 2'b01,
		VIS_KIND_MASKABLE = 2'b10,
		VIS_KIND_SOFTWARE = 2'b11
	} vis_kind_t;

	typedef struct packed {
		logic valid;
		vis_kind_t kind;
		logic [3:0] prio;
		logic [15:0] vector;
	} vis_req_t;

	typedef struct packed {
		logic t16_ch0_compare;
		logic t16_ch1_compare;
		logic t16_ch0_match;
		logic t16_ch1_match;
		logic capture_input_0_edge;
		logic capture_input_1_edge;
	} vis_timer16_t;

endpackage

// ===== design/vis_edge_detect.sv
// Purpose: synchronise one pin and flag its selected edge
// Assumes: pin is asynchronous to ref_clk_i
// Notes: output is a one-cycle pulse
module vis_edge_detect
	import vis_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// Pin and mode
	input wire logic pin_i,
	input wire vis_edge_t mode_i,
	// Event
	output logic edge_o
);

	logic [1:0] sync_ff;
	logic prev_ff;
	logic [1:0] fill_ff;
	logic primed;
	logic rise;
	logic fall;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_ff <= VIS_SYNC_RST;
			prev_ff <= 1'b0;
			fill_ff <= VIS_SYNC_RST;
		end else if (clk_en_i) begin
			sync_ff <= {sync_ff[0], pin_i};
			prev_ff <= sync_ff[1];
			if (!primed) begin
				fill_ff <= fill_ff + 2'h1;
			end
		end
	end

	// No edge until prev holds a real pin sample
	assign primed = &fill_ff;
	assign rise = primed & sync_ff[1] & ~prev_ff;
	assign fall = primed & ~sync_ff[1] & prev_ff;
	// Edge selection per pin
	assign edge_o = clk_en_i & (
		(mode_i == VIS_EDGE_RISE & rise) |
		(mode_i == VIS_EDGE_FALL & fall) |
		(mode_i == VIS_EDGE_BOTH & (rise | fall)));

endmodule

// ===== design/vis_sources.sv
// Purpose: collect, latch, rank and vector the interrupt sources
// Assumes: peripherals give one-cycle event pulses on ref_clk_i
// Notes: CPU takes a request with ack_i, then the flag clears
// ************************************************************
// Notes on behaviour
// ************************************************************
// Notes on behaviour
// - Eighteen sources: one non-maskable, sixteen maskable, one software.
// - Watchdog overflow in non-maskable mode raises NMI at vector 0004H.
// - Watchdog overflow in interval mode raises maskable priority 0.
// - Pending maskable requests served lowest number first, 0 to 15.
// - External pins 0,1,2 give priorities 1,2,3 at 0006H,0008H,000AH.
// - Each external pin triggers on rising, falling or both edges.
// - Bus receive edge in standby raises wake-up, priority 4, 000CH.
// - Timer16 channel 0: compare match or capture input 1 edge, 000EH.
// - Timer16 channel 1: compare match or capture input 0 edge, 0010H.
// - Timer six match raises priority 7 at 0012H.
// - Timer eighty match raises priority 8 at 0014H.
// - Timer eightyone match raises priority 9 at 0016H.
// - Bus transfer done raises priority 10 at 0018H.
// - Bus rx error 11, serial 12, uart rx 13, tx 14, adc 15.
// - Software break raises software interrupt at 003EH.
module vis_sources
	import vis_pkg::*;
#(
	parameter int NUM_MASKABLE = VIS_NUM_MASKABLE,
	parameter int NUM_EXT = VIS_NUM_EXT
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// Watchdog
	input wire logic wdt_overflow_i,
	input wire logic wdt_nmi_mode_i,
	// External pins
	input wire logic [NUM_EXT-1:0] ext_pin_i,
	input wire vis_edge_t [NUM_EXT-1:0] ext_edge_mode_i,
	// Multiplex bus
	input wire logic body_bus_receive_in_i,
	input wire logic standby_rx_i,
	input wire logic bus_xfer_done_i,
	input wire logic bus_rx_error_i,
	// Timers
	input wire vis_timer16_t timer16_i,
	input wire logic timer_six_match_i,
	input wire logic timer_eighty_match_i,
	input wire logic timer_eightyone_match_i,
	// Serial and converter
	input wire logic csi_end_i,
	input wire logic uart_rx_end_i,
	input wire logic uart_tx_end_i,
	input wire logic adc_end_i,
	// CPU side
	input wire logic software_break_i,
	input wire logic global_enable_i,
	input wire logic [NUM_MASKABLE-1:0] mask_i,
	input wire logic ack_i,
	// Request to CPU
	output vis_req_t req_o,
	output logic [NUM_MASKABLE-1:0] pending_o,
	output logic nmi_pending_o
);

	// ************************************************************
	// Event sources
	// ************************************************************
	logic [NUM_EXT-1:0] ext_edge;
	logic [1:0] bus_sync_ff;
	logic bus_prev_ff;
	logic [1:0] bus_fill_ff;
	logic bus_primed;
	logic wake_edge;
	logic [NUM_MASKABLE-1:0] src_evt;
	logic t16_ch0_evt;
	logic t16_ch1_evt;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
			vis_edge_detect u_edge (
				.ref_clk_i(ref_clk_i),
				.rst_i(rst_i),
				.clk_en_i(clk_en_i),
				.pin_i(ext_pin_i[gi]),
				.mode_i(ext_edge_mode_i[gi]),
				.edge_o(ext_edge[gi])
			);
		end
	endgenerate

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_sync_ff <= VIS_SYNC_RST;
			bus_prev_ff <= 1'b0;
			bus_fill_ff <= VIS_SYNC_RST;
		end else if (clk_en_i) begin
			bus_sync_ff <= {bus_sync_ff[0], body_bus_receive_in_i};
			bus_prev_ff <= bus_sync_ff[1];
			if (!bus_primed) begin
				bus_fill_ff <= bus_fill_ff + 2'h1;
			end
		end
	end

	// No false wake-up from the reset value of prev
	assign bus_primed = &bus_fill_ff;
	assign wake_edge = standby_rx_i & bus_primed
		& (bus_sync_ff[1] ^ bus_prev_ff);

	assign t16_ch0_evt = timer16_i.t16_ch0_compare ?
		timer16_i.t16_ch0_match : timer16_i.capture_input_1_edge;
	assign t16_ch1_evt = timer16_i.t16_ch1_compare ?
		timer16_i.t16_ch1_match : timer16_i.capture_input_0_edge;

	always_comb begin
		src_evt = '0;
		src_evt[VIS_SRC_WDT_INTERVAL] = wdt_overflow_i & ~wdt_nmi_mode_i;
		src_evt[VIS_SRC_EXT0 +: 3] = ext_edge[2:0];
		src_evt[VIS_SRC_WAKEUP] = wake_edge;
		src_evt[VIS_SRC_T16_CH0] = t16_ch0_evt;
		src_evt[VIS_SRC_T16_CH1] = t16_ch1_evt;
		src_evt[VIS_SRC_TIMER_SIX] = timer_six_match_i;
		src_evt[VIS_SRC_TIMER_EIGHTY] = timer_eighty_match_i;
		src_evt[VIS_SRC_TIMER_EIGHTYONE] = timer_eightyone_match_i;
		src_evt[VIS_SRC_BUS_XFER] = bus_xfer_done_i;
		src_evt[VIS_SRC_BUS_RX_ERR] = bus_rx_error_i;
		src_evt[VIS_SRC_CSI_END] = csi_end_i;
		src_evt[VIS_SRC_UART_RX] = uart_rx_end_i;
		src_evt[VIS_SRC_UART_TX] = uart_tx_end_i;
		src_evt[VIS_SRC_ADC_END] = adc_end_i;
	end

	// ************************************************************
	// Request flags
	// ************************************************************
	logic [NUM_MASKABLE-1:0] pend_ff;
	logic [NUM_MASKABLE-1:0] nxt_pend;
	logic nmi_ff;
	logic nxt_nmi;
	logic swi_ff;
	logic nxt_swi;
	vis_req_t req_ff;
	vis_req_t nxt_req;
	logic [NUM_MASKABLE-1:0] eligible;
	logic [NUM_MASKABLE-1:0] win_onehot;
	logic [NUM_MASKABLE-1:0] clr_mask;
	logic [3:0] win_idx;
	logic win_any;
	logic take;

	assign take = ack_i & req_ff.valid;
	assign eligible = pend_ff & ~mask_i & {NUM_MASKABLE{global_enable_i}};
	assign win_onehot = eligible & (~eligible + 1'b1);
	assign win_any = |eligible;

	always_comb begin
		win_idx = '0;
		for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
			if (eligible[i]) begin
				win_idx = 4'(i);
			end
		end
	end

	// Clear only the flag that was offered and taken
	always_comb begin
		clr_mask = '0;
		if (take && req_ff.kind == VIS_KIND_MASKABLE) begin
			clr_mask[req_ff.prio] = 1'b1;
		end
	end

	// Set wins over clear in the same cycle
	assign nxt_pend = (pend_ff & ~clr_mask) | src_evt;
	assign nxt_nmi = (nmi_ff & ~(take && req_ff.kind == VIS_KIND_NMI))
		| (wdt_overflow_i & wdt_nmi_mode_i);
	assign nxt_swi = (swi_ff & ~(take && req_ff.kind == VIS_KIND_SOFTWARE))
		| software_break_i;

	// ************************************************************
	// Selection and vector
	// ************************************************************
	always_comb begin
		nxt_req = '0;
		nxt_req.kind = VIS_KIND_NONE;
		nxt_req.vector = VIS_VEC_NONE;
		if (nxt_nmi) begin
			nxt_req.valid = 1'b1;
			nxt_req.kind = VIS_KIND_NMI;
			nxt_req.vector = VIS_VEC_NMI;
		end else if (nxt_swi) begin
			nxt_req.valid = 1'b1;
			nxt_req.kind = VIS_KIND_SOFTWARE;
			nxt_req.vector = VIS_VEC_SOFTWARE;
		end else if (win_any && (nxt_pend & win_onehot) != '0) begin
			nxt_req.valid = 1'b1;
			nxt_req.kind = VIS_KIND_MASKABLE;
			nxt_req.prio = win_idx;
			nxt_req.vector = VIS_VEC_MASK_BASE
				+ {11'h000, win_idx, 1'b0};
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_ff <= VIS_PEND_RST;
			nmi_ff <= 1'b0;
			swi_ff <= 1'b0;
			req_ff <= '0;
		end else if (clk_en_i) begin
			pend_ff <= nxt_pend;
			nmi_ff <= nxt_nmi;
			swi_ff <= nxt_swi;
			req_ff <= nxt_req;
		end
	end

	assign req_o = req_ff;
	assign pending_o = pend_ff;
	assign nmi_pending_o = nmi_ff;

endmodule

// ===== bench/vis_sources_assertions.sv
// Purpose: port checks for the interrupt source block
// Assumes: one clock, asynchronous active high reset
// Notes: bound to vis_sources
module vis_sources_assertions
	import vis_pkg::*;
#(
	parameter int NUM_MASKABLE = 16,
	parameter int NUM_EXT = 3
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// Events
	input wire logic wdt_overflow_i,
	input wire logic wdt_nmi_mode_i,
	input wire logic timer_six_match_i,
	input wire logic software_break_i,
	// CPU side
	input wire logic global_enable_i,
	input wire logic [NUM_MASKABLE-1:0] mask_i,
	input wire logic ack_i,
	input wire vis_req_t req_o,
	input wire logic [NUM_MASKABLE-1:0] pending_o,
	input wire logic nmi_pending_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		ack_i && req_o.valid && clk_en_i;
	endsequence
	sequence s_shown;
		req_o.valid && req_o.kind == VIS_KIND_MASKABLE;
	endsequence
	chk_nmi_raise: assert property (wdt_overflow_i && wdt_nmi_mode_i
		&& clk_en_i |=> nmi_pending_o) else $error("nmi flag missing");
	chk_wdt_interval: assert property (wdt_overflow_i &&
		!wdt_nmi_mode_i && clk_en_i |=> pending_o[0]) else $error("wdt flag");
	chk_nmi_wins: assert property (nmi_pending_o |-> req_o.valid &&
		req_o.kind == VIS_KIND_NMI && req_o.vector == VIS_VEC_NMI)
		else $error("nmi not shown");
	chk_rank_order: assert property (s_shown ##0 ($stable(pending_o) &&
		$stable(mask_i)) |-> (pending_o & ~mask_i &
		((16'h1 << req_o.prio) - 16'h1)) == 16'h0) else $error("rank");
	chk_shown_pending: assert property (s_shown |->
		pending_o[req_o.prio]) else $error("shown without flag");
	chk_vec_map: assert property (s_shown ##0 (req_o.prio != 4'h0) |->
		req_o.vector == 16'h0004 + {11'h0, req_o.prio, 1'b0})
		else $error("vector");
	chk_flag_hold: assert property (!ack_i && clk_en_i |=>
		($past(pending_o) & ~pending_o) == 16'h0) else $error("flag lost");
	chk_ack_clear: assert property (s_take ##0
		(req_o.kind == VIS_KIND_MASKABLE) |=>
		!pending_o[$past(req_o.prio)]) else $error("ack kept flag");
	chk_soft_vec: assert property (software_break_i && clk_en_i &&
		!wdt_overflow_i && !nmi_pending_o |=> req_o.valid &&
		req_o.kind == VIS_KIND_SOFTWARE &&
		req_o.vector == VIS_VEC_SOFTWARE) else $error("break");
	chk_six_match: assert property (timer_six_match_i && clk_en_i
		|=> pending_o[VIS_SRC_TIMER_SIX]) else $error("timer six");
	chk_gate_off: assert property (!global_enable_i [*2] |->
		req_o.kind != VIS_KIND_MASKABLE) else $error("gated shown");
endmodule
bind vis_sources vis_sources_assertions #(.NUM_MASKABLE(NUM_MASKABLE),
	.NUM_EXT(NUM_EXT)) i_chk (.*);

// ===== bench/vis_cpu_model.sv
// Purpose: CPU core that accepts shown requests
// Assumes: shares the system clock
// Notes: raises ack after dly_i + 1 cycles of valid
module vis_cpu_model
	import vis_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Request side
	input wire vis_req_t req_i,
	input wire logic [3:0] dly_i,
	output logic ack_o
);
	logic [3:0] wait_ff;
	// Ack pulsed for one cycle, then dropped and the count restarts
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			wait_ff <= 4'h0;
		end else if (ack_o || !req_i.valid) begin
			ack_o <= 1'b0;
			wait_ff <= 4'h0;
		end else if (wait_ff >= dly_i) begin
			ack_o <= 1'b1;
		end else begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule

// ===== bench/tb_vectored_interrupt_sources.sv
// Purpose: scenarios for the interrupt source block
// Assumes: CPU model acks shown requests
// Notes: requests judged at the falling edge before the edge they are taken
module tb_vectored_interrupt_sources
	import vis_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst, nmi_m, std, brx, software_break, gen, ack, en;
	logic [2:0] pin;
	vis_edge_t [2:0] mode;
	logic [15:0] src, mask, pend;
	vis_timer16_t t16;
	vis_req_t req;
	logic nmi_p;
	logic [3:0] dly;
	int err_count, compares;
	vis_sources i_dut (.ref_clk_i(clk), .rst_i(rst), .clk_en_i(en),
		.wdt_overflow_i(src[0]), .wdt_nmi_mode_i(nmi_m),
		.ext_pin_i(pin), .ext_edge_mode_i(mode),
		.body_bus_receive_in_i(brx), .standby_rx_i(std),
		.bus_xfer_done_i(src[10]), .bus_rx_error_i(src[11]),
		.timer16_i(t16), .timer_six_match_i(src[7]),
		.timer_eighty_match_i(src[8]), .timer_eightyone_match_i(src[9]),
		.csi_end_i(src[12]), .uart_rx_end_i(src[13]),
		.uart_tx_end_i(src[14]), .adc_end_i(src[15]),
		.software_break_i(software_break), .global_enable_i(gen), .mask_i(mask),
		.ack_i(ack), .req_o(req), .pending_o(pend), .nmi_pending_o(nmi_p));
	vis_cpu_model i_cpu (.ref_clk_i(clk), .rst_i(rst), .req_i(req),
		.dly_i(dly), .ack_o(ack));
	always #12.5 clk = ~clk;
	task results;
		$display("mismatches %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [22:0] got, input logic [22:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Wait for the next acceptance and judge what was shown
	task take(input vis_kind_t k, input logic [3:0] p);
		int n;
		vis_req_t e;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		if (ack !== 1'b1) begin
			err_count++;
			results();
		end
		e = {1'b1, k, p, 16'h0004 + {11'h0, p, 1'b0}};
		if (k == VIS_KIND_NMI)
			e.vector = VIS_VEC_NMI;
		if (k == VIS_KIND_SOFTWARE)
			e.vector = VIS_VEC_SOFTWARE;
		chk(req, e);
	endtask
	task pulse(input logic [15:0] s, input logic [5:0] t);
		@(posedge clk);
		src <= s;
		t16 <= t;
		@(posedge clk);
		src <= 16'h0;
		t16 <= {t[5:4], 4'h0};
	endtask
	task t_rank;
		dly <= 4'h3;
		pulse(16'hff81, 6'h3c);
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk({7'h0, pend}, 23'h00ffe1);
		@(posedge clk);
		mask <= 16'h0;
		for (int p = 0; p < 16; p++)
			if (p == 0 || p > 4)
				take(VIS_KIND_MASKABLE, p[3:0]);
	endtask
	task t_capture;
		@(posedge clk);
		dly <= 4'h0;
		pulse(16'h0, 6'h01);
		take(VIS_KIND_MASKABLE, 4'h5);
		pulse(16'h0, 6'h02);
		take(VIS_KIND_MASKABLE, 4'h6);
	endtask
	task t_pins;
		@(posedge clk);
		pin <= 3'b111;
		take(VIS_KIND_MASKABLE, 4'h1);
		take(VIS_KIND_MASKABLE, 4'h3);
		@(posedge clk);
		pin <= 3'b000;
		take(VIS_KIND_MASKABLE, 4'h2);
		take(VIS_KIND_MASKABLE, 4'h3);
		repeat (6) @(posedge clk);
		@(negedge clk);
		chk({7'h0, pend}, 23'h0);
		@(posedge clk);
		std <= 1'b1;
		brx <= 1'b1;
		take(VIS_KIND_MASKABLE, 4'h4);
	endtask
	// Event while frozen is dropped and leaves no flag
	task t_freeze;
		@(posedge clk);
		en <= 1'b0;
		pulse(16'h0080, 6'h0);
		repeat (3) @(posedge clk);
		en <= 1'b1;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk({7'h0, pend}, 23'h0);
	endtask
	task t_nmi;
		@(posedge clk);
		gen <= 1'b0;
		mask <= 16'hffff;
		nmi_m <= 1'b1;
		dly <= 4'h1;
		pulse(16'h0080, 6'h0);
		software_break <= 1'b1;
		@(posedge clk);
		software_break <= 1'b0;
		src <= 16'h0001;
		@(posedge clk);
		src <= 16'h0;
		take(VIS_KIND_NMI, 4'h0);
		take(VIS_KIND_SOFTWARE, 4'h0);
		chk({7'h0, pend}, 23'h000080);
		@(posedge clk);
		gen <= 1'b1;
		mask <= 16'h0;
		take(VIS_KIND_MASKABLE, 4'h7);
	endtask
	initial begin
		clk = 0;
		rst = 1;
		{nmi_m, std, brx, software_break} = 4'h0;
		gen = 1;
		en = 1;
		pin = 3'b010;
		mode[0] = VIS_EDGE_RISE;
		mode[1] = VIS_EDGE_FALL;
		mode[2] = VIS_EDGE_BOTH;
		src = 16'h0;
		mask = 16'hffff;
		t16 = 6'h0;
		dly = 4'h0;
		err_count = 0;
		compares = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_rank();
		t_capture();
		t_pins();
		t_freeze();
		t_nmi();
		results();
	end
endmodule
